/* ilmp_ctrl.sv */
// Interrupt level controller: mask, priority and request registers.
// Assumes sources give one-cycle request pulses on the same clock and
// that the core acknowledges through ack_i after seeing irq_o.
`timescale 1ns/1ps

module ilmp_ctrl #(
  parameter int unsigned NLVL = ilmp_pkg::NUM_LEVELS
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic            reg_wr_i,
  input  wire logic [7:0]      reg_wdata_i,
  output logic      [7:0]      reg_rdata_o,
  input  wire logic            src_timer0_i,
  input  wire logic            src_timer1_i,
  input  wire logic            src_counter_a_i,
  input  wire logic            src_free_running_timer_i,
  input  wire logic            src_serial_i,
  input  wire logic            src_timer2_i,
  input  wire logic [1:0]      src_port2_i,
  input  wire logic [1:0]      src_port0_i,
  input  wire logic [NLVL-1:0] src_enable_i,
  input  wire logic [NLVL-1:0] sw_clear_i,
  input  wire logic            enable_interrupts_instr_i,
  input  wire logic            disable_interrupts_instr_i,
  input  wire logic            return_from_interrupt_i,
  input  wire logic            ack_i,
  output logic                 irq_o,
  output logic [2:0]           irq_level_o,
  output logic [2:0]           irq_source_o,
  output logic                 global_enable_o,
  output logic [NLVL-1:0]      auto_clear_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]            level_mask;
  logic [7:0]            level_priority;
  logic [NLVL-1:0]       level_request_status;
  logic                  global_enable;
  ilmp_pkg::ilmp_state_t state;

  // ----------------------------------------------------------------
  // Source to level mapping
  // ----------------------------------------------------------------
  wire [NLVL-1:0] level_event;
  assign level_event[0] = src_timer0_i;
  assign level_event[1] = src_timer1_i;
  assign level_event[2] = src_counter_a_i | src_free_running_timer_i | src_serial_i;
  assign level_event[3] = src_timer2_i;
  assign level_event[5:4] = src_port2_i;
  assign level_event[7:6] = src_port0_i;

  // Within level 2 the lowest vector wins: counter, timer match, serial.
  wire [2:0] lvl2_source = src_counter_a_i          ? 3'h0 :
                           src_free_running_timer_i ? 3'h1 :
                           src_serial_i             ? 3'h2 : 3'h0;
  logic [2:0] lvl2_held;

  // ----------------------------------------------------------------
  // Eligibility and priority resolution
  // ----------------------------------------------------------------
  wire [NLVL-1:0] eligible = level_request_status & level_mask & src_enable_i;

  wire p_a  = level_priority[ilmp_pkg::PRI_GRP_A];
  wire p_bg = level_priority[ilmp_pkg::PRI_GRP_B];
  wire p_bs = level_priority[ilmp_pkg::PRI_SUB_B];
  wire p_cg = level_priority[ilmp_pkg::PRI_GRP_C];
  wire p_cs = level_priority[ilmp_pkg::PRI_SUB_C];

  // Winner inside each group.
  wire [2:0] a_lvl = (eligible[1] & (p_a | ~eligible[0])) ? 3'h1 : 3'h0;
  wire       a_any = |eligible[1:0];
  wire [2:0] b_sub = (eligible[4] & (p_bs | ~eligible[3])) ? 3'h4 : 3'h3;
  wire       b_sub_any = |eligible[4:3];
  wire [2:0] b_lvl = (b_sub_any & (p_bg | ~eligible[2])) ? b_sub : 3'h2;
  wire       b_any = |eligible[4:2];
  wire [2:0] c_sub = (eligible[7] & (p_cs | ~eligible[6])) ? 3'h7 : 3'h6;
  wire       c_sub_any = |eligible[7:6];
  wire [2:0] c_lvl = (c_sub_any & (p_cg | ~eligible[5])) ? c_sub : 3'h5;
  wire       c_any = |eligible[7:5];

  // Group order code, bit 7 most significant.
  wire [2:0] order = {level_priority[ilmp_pkg::PRI_GRP_HI],
                      level_priority[ilmp_pkg::PRI_GRP_MID],
                      level_priority[ilmp_pkg::PRI_GRP_LO]};

  logic [2:0] win_lvl;
  logic       win_any;
  assign win_any = a_any | b_any | c_any;

  always_comb begin
    case (order)
      ilmp_pkg::ORD_BCA: win_lvl = b_any ? b_lvl : (c_any ? c_lvl : a_lvl);
      ilmp_pkg::ORD_BAC: win_lvl = b_any ? b_lvl : (a_any ? a_lvl : c_lvl);
      ilmp_pkg::ORD_CAB: win_lvl = c_any ? c_lvl : (a_any ? a_lvl : b_lvl);
      ilmp_pkg::ORD_CBA: win_lvl = c_any ? c_lvl : (b_any ? b_lvl : a_lvl);
      ilmp_pkg::ORD_ACB: win_lvl = a_any ? a_lvl : (c_any ? c_lvl : b_lvl);
      // Undefined codes still resolve so no request is stranded.
      default:           win_lvl = a_any ? a_lvl : (b_any ? b_lvl : c_lvl);
    endcase
  end

  // Only offered when globally enabled; the core decides when to take it.
  wire offer = win_any & global_enable;
  wire take  = (state == ilmp_pkg::ILMP_ACK) & ack_i;

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  wire wr_mask = reg_wr_i & (reg_addr_i == ilmp_pkg::ADDR_LEVEL_MASK);
  wire wr_pri  = reg_wr_i & (reg_addr_i == ilmp_pkg::ADDR_LEVEL_PRIORITY);

  wire [7:0] rd_mux =
    (reg_addr_i == ilmp_pkg::ADDR_LEVEL_REQUEST_STATUS) ? level_request_status :
    (reg_addr_i == ilmp_pkg::ADDR_LEVEL_MASK)           ? level_mask :
    (reg_addr_i == ilmp_pkg::ADDR_LEVEL_PRIORITY)       ? level_priority : 8'h00;

  // Clearing on service: only hardware-cleared levels, only the one taken.
  wire [NLVL-1:0] taken_onehot = take ? (NLVL'(1) << irq_level_o) : '0;
  wire [NLVL-1:0] hw_clear = taken_onehot & ilmp_pkg::AUTO_CLEAR_LEVELS;
  wire [NLVL-1:0] next_request;

  // ----------------------------------------------------------------
  // Request latch per level
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NLVL; g++) begin : g_req
      // A new event wins over a clear in the same cycle; recording
      // ignores the global enable so polling still sees it.
      assign next_request[g] = level_event[g] |
                               (level_request_status[g] & ~hw_clear[g] & ~sw_clear_i[g]);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_request_status <= ilmp_pkg::RST_LEVEL_REQUEST_STATUS;
    end else begin
      level_request_status <= next_request;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_mask     <= ilmp_pkg::RST_LEVEL_MASK;
      level_priority <= ilmp_pkg::RST_LEVEL_PRIORITY;
    end else begin
      if (wr_mask) begin
        level_mask <= reg_wdata_i;
      end
      if (wr_pri) begin
        level_priority <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Global enable and acknowledge sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_enable <= 1'b0;
    end else if (take | disable_interrupts_instr_i) begin
      global_enable <= 1'b0;
    end else if (return_from_interrupt_i | enable_interrupts_instr_i) begin
      global_enable <= 1'b1;
    end
  end

  // A later level 2 source may only take over a pending level when its vector
  // is lower, so an earlier counter event is not hidden by a serial event.
  wire lvl2_empty = ~level_request_status[2] | hw_clear[2] | sw_clear_i[2];
  wire lvl2_load  = level_event[2] & (lvl2_empty | (lvl2_source < lvl2_held));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl2_held <= 3'h0;
    end else if (lvl2_load) begin
      lvl2_held <= lvl2_source;
    end
  end

  // Level and source are frozen while offered so the core sees a stable pair.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= ilmp_pkg::ILMP_IDLE;
      irq_o        <= 1'b0;
      irq_level_o  <= 3'h0;
      irq_source_o <= 3'h0;
    end else begin
      case (state)
        ilmp_pkg::ILMP_IDLE: begin
          if (offer) begin
            state        <= ilmp_pkg::ILMP_ACK;
            irq_o        <= 1'b1;
            irq_level_o  <= win_lvl;
            irq_source_o <= (win_lvl == 3'h2) ? lvl2_held : 3'h0;
          end
        end
        ilmp_pkg::ILMP_ACK: begin
          if (ack_i | ~global_enable) begin
            state <= ilmp_pkg::ILMP_IDLE;
            irq_o <= 1'b0;
          end
        end
        default: begin
          state <= ilmp_pkg::ILMP_IDLE;
          irq_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o     <= 8'h00;
      global_enable_o <= 1'b0;
      auto_clear_o    <= '0;
    end else begin
      reg_rdata_o     <= rd_mux;
      global_enable_o <= global_enable;
      auto_clear_o    <= hw_clear;
    end
  end

endmodule : ilmp_ctrl

/* ilmp_pkg.sv */
// Package for the interrupt level mask and priority controller.
// Assumes an 8-bit register file port driven by the processor core.
package ilmp_pkg;

  localparam int unsigned NUM_LEVELS = 8;

  // ----------------------------------------------------------------
  // Register locations
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LEVEL_REQUEST_STATUS = 8'hdc;
  localparam logic [7:0] ADDR_LEVEL_MASK           = 8'hdd;
  localparam logic [7:0] ADDR_LEVEL_PRIORITY       = 8'hff;

  // Reset values; mask and priority are undefined, so zero is chosen.
  localparam logic [7:0] RST_LEVEL_REQUEST_STATUS  = 8'h00;
  localparam logic [7:0] RST_LEVEL_MASK            = 8'h00;
  localparam logic [7:0] RST_LEVEL_PRIORITY        = 8'h00;

  // ----------------------------------------------------------------
  // Priority register fields
  // ----------------------------------------------------------------
  localparam int unsigned PRI_GRP_HI  = 7;
  localparam int unsigned PRI_SUB_C   = 6;
  localparam int unsigned PRI_GRP_C   = 5;
  localparam int unsigned PRI_GRP_MID = 4;
  localparam int unsigned PRI_SUB_B   = 3;
  localparam int unsigned PRI_GRP_B   = 2;
  localparam int unsigned PRI_GRP_LO  = 1;
  localparam int unsigned PRI_GRP_A   = 0;

  // Group order codes (bit 7, bit 4, bit 1).
  localparam logic [2:0] ORD_BCA = 3'h1;
  localparam logic [2:0] ORD_ABC = 3'h2;
  localparam logic [2:0] ORD_BAC = 3'h3;
  localparam logic [2:0] ORD_CAB = 3'h4;
  localparam logic [2:0] ORD_CBA = 3'h5;
  localparam logic [2:0] ORD_ACB = 3'h6;

  // Levels whose pending condition clears on acknowledge.
  localparam logic [7:0] AUTO_CLEAR_LEVELS = 8'h0f;

  typedef enum logic [1:0] {
    ILMP_IDLE,
    ILMP_ACK
  } ilmp_state_t;

endpackage : ilmp_pkg

/* ilmp_core_model.sv */
// Processor core model: acknowledges an offered request after a delay.
// Assumes irq_i stays up until ack_o has been seen high for one edge.
`timescale 1ns/1ps
module ilmp_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_i,
  input  wire logic [3:0] dly_i,
  output logic            ack_o
);
  logic [3:0] wait_cnt;
  // A zero delay answers at the first edge that sees the request.
  always_ff @(posedge clk_i) begin
    if (rst_i || ack_o || !irq_i) begin
      ack_o    <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == dly_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : ilmp_core_model

/* ilmp_ctrl_sva.sv */
// Checker for the level controller, bound to every ilmp_ctrl.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ilmp_ctrl_sva #(
  parameter int unsigned NLVL = 8
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic [7:0]      reg_addr_i,
  input wire logic            reg_wr_i,
  input wire logic [7:0]      reg_wdata_i,
  input wire logic [7:0]      reg_rdata_o,
  input wire logic            enable_interrupts_instr_i,
  input wire logic            disable_interrupts_instr_i,
  input wire logic            return_from_interrupt_i,
  input wire logic            ack_i,
  input wire logic            irq_o,
  input wire logic [2:0]      irq_level_o,
  input wire logic            global_enable_o,
  input wire logic [NLVL-1:0] auto_clear_o
);
  localparam logic [NLVL-1:0] ONE = 1;
  wire [NLVL-1:0] auto_lv = NLVL'(ilmp_pkg::AUTO_CLEAR_LEVELS);
  wire msk_a  = reg_addr_i == ilmp_pkg::ADDR_LEVEL_MASK;
  wire pri_a  = reg_addr_i == ilmp_pkg::ADDR_LEVEL_PRIORITY;
  wire set_ge = (enable_interrupts_instr_i || return_from_interrupt_i)
                && !disable_interrupts_instr_i && !ack_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  rst_clear_a: assert property ($fell(rst_i) |-> reg_rdata_o == 8'h00 && !irq_o)
    else $error("outputs not clear after reset");
  mask_rw_a: assert property (reg_wr_i && msk_a ##1 !reg_wr_i && msk_a |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("mask readback wrong");
  pri_rw_a: assert property (reg_wr_i && pri_a ##1 !reg_wr_i && pri_a |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("priority readback wrong");
  ack_drop_a: assert property (irq_o && ack_i |=> !irq_o ##1 !global_enable_o)
    else $error("acknowledge did not block requests");
  ge_set_a: assert property (set_ge |-> ##[1:2] global_enable_o)
    else $error("global enable not set");
  ge_clr_a: assert property (disable_interrupts_instr_i |-> ##[1:2] !global_enable_o)
    else $error("global enable not cleared");
  irq_gate_a: assert property (!global_enable_o [*3] |-> !irq_o)
    else $error("request offered while disabled");
  clr_lvl_a: assert property (irq_o && ack_i |=> auto_clear_o == (auto_lv & (ONE << $past(irq_level_o))))
    else $error("wrong hardware clear");
  clr_cause_a: assert property (auto_clear_o != '0 |-> $past(irq_o && ack_i))
    else $error("hardware clear without acknowledge");
  cover property (irq_o && ack_i && irq_level_o == 3'h7);
  cover property (auto_clear_o != '0);
  cover property (reg_wr_i && pri_a);
endmodule : ilmp_ctrl_sva

bind ilmp_ctrl ilmp_ctrl_sva #(.NLVL(NLVL)) u_sva (.*);

/* tb_top.sv */
// Testbench for the level controller: registers, source map, priority.
// Assumes a core model that acknowledges after a programmable delay.
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic        wr    = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [20:0] stb   = 21'h0;
  logic [7:0]  en    = 8'h00;
  logic [3:0]  dly   = 4'h0;
  logic [7:0]  rdata, aclr;
  logic        ack, irq, ge;
  logic [2:0]  lvl, srcsel;
  int          errors = 0;
  int          n_compared = 0;
  // Entries are priority, mask, source enable, expected level.
  logic [31:0] tbl [18] = '{32'h02ffff02, 32'h16ffff03, 32'h1effff04, 32'h10ffff00,
    32'h11ffff01, 32'h80ffff05, 32'ha0ffff06, 32'he0ffff07, 32'h82ffff05, 32'h90fcff05,
    32'h00ffff00, 32'h92fcff02, 32'h10feff01, 32'h10fffe01, 32'h02e3ff05, 32'h801fff00,
    32'h821fff02, 32'h12e3ff00};
  logic [7:0]  lmap [10] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h04, 8'h08, 8'h10, 8'h20,
    8'h40, 8'h80};
  ilmp_ctrl DUT (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .src_timer0_i(stb[0]), .src_timer1_i(stb[1]), .src_counter_a_i(stb[2]),
    .src_free_running_timer_i(stb[3]), .src_serial_i(stb[4]), .src_timer2_i(stb[5]),
    .src_port2_i(stb[7:6]), .src_port0_i(stb[9:8]), .src_enable_i(en),
    .sw_clear_i(stb[20:13]), .enable_interrupts_instr_i(stb[10]),
    .disable_interrupts_instr_i(stb[11]), .return_from_interrupt_i(stb[12]),
    .ack_i(ack), .irq_o(irq), .irq_level_o(lvl), .irq_source_o(srcsel),
    .global_enable_o(ge), .auto_clear_o(aclr));
  ilmp_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .dly_i(dly), .ack_o(ack));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wr    <= 1'b1;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(rdata, exp);
  endtask : rd_chk
  // Strobe bits: sources 9:0, enable 10, disable 11, return 12, clears 20:13.
  task automatic pulse(input logic [20:0] v);
    @(posedge clk_i);
    stb <= v;
    @(posedge clk_i);
    stb <= 21'h0;
  endtask : pulse
  // Returns at the falling edge on which the core model shows its acknowledge.
  task automatic wait_ack();
    int n;
    n = 0;
    while (ack !== 1'b1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_ack
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'hdc, 8'h00);
    wr_reg(8'hdd, 8'ha5);
    wr_reg(8'hff, 8'h3c);
    wr_reg(8'hdc, 8'hff);
    rd_chk(8'hdd, 8'ha5);
    rd_chk(8'hff, 8'h3c);
    rd_chk(8'hdc, 8'h00);
    rd_chk(8'h10, 8'h00);
    // Global enable is still off here, so requests are only recorded.
    for (int k = 0; k < 10; k++) begin
      pulse(21'h1 << k);
      rd_chk(8'hdc, lmap[k]);
      chk({7'h00, irq}, 8'h00);
      pulse(21'h1fe000);
    end
    for (int i = 0; i < 18; i++) begin
      @(posedge clk_i);
      en  <= tbl[i][15:8];
      dly <= 4'(i);
      wr_reg(8'hdd, tbl[i][23:16]);
      wr_reg(8'hff, tbl[i][31:24]);
      pulse(21'h3ff);
      pulse(i[0] ? 21'h1000 : 21'h400);
      wait_ack();
      chk({7'h00, ack}, 8'h01);
      chk({7'h00, irq}, 8'h01);
      chk({5'h00, lvl}, tbl[i][7:0]);
      chk({5'h00, srcsel}, 8'h00);
      @(negedge clk_i);
      chk(aclr, (tbl[i][7:0] < 8'h04) ? (8'h01 << tbl[i][2:0]) : 8'h00);
      rd_chk(8'hdc, (tbl[i][7:0] < 8'h04) ? ~(8'h01 << tbl[i][2:0]) : 8'hff);
      chk({7'h00, ge}, 8'h00);
      pulse(21'h1fe000);
    end
    // Level 2 keeps the lowest vector among the sources still pending on it.
    wr_reg(8'hdd, 8'hff);
    pulse(21'h10);
    pulse(21'h8);
    pulse(21'h400);
    wait_ack();
    chk({5'h00, lvl}, 8'h02);
    chk({5'h00, srcsel}, 8'h01);
    pulse(21'h400);
    repeat (2) @(negedge clk_i);
    chk({7'h00, ge}, 8'h01);
    pulse(21'h800);
    repeat (2) @(negedge clk_i);
    chk({7'h00, ge}, 8'h00);
    // A reset in mid-run must drop requests that are still pending.
    pulse(21'h3ff);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'hdc, 8'h00);
    wrap_up();
  end
endmodule : tb_top
